//--- logic/ood_option_decode.v
// Option byte loader, decoder and programming-mode address map.
//
// Functional notes
// - Programmer 4000H-7FFFH maps program C000H-FFFFH.
// - Option bytes sit at 3FF0H through 3FF6H.
// - First byte bit0 set enables power-on reset.
// - First byte bit1 picks crystal, else ceramic.
// - First byte bit2 drives reset out pin.
// - First byte bits 3-7 are vacant storage.
// - Bytes two and three: pull-ups, zero enables.
// - Wait after power-on reset and stop wake-up.
// - Plain 32Kx8 EPROM, no electronic signature.
`timescale 1ns/100ps
`default_nettype none
`include "ood_regs.vh"

module ood_option_decode
(
  // Clock and reset.
  input  wire        clk,
  input  wire        reset_n,
  // Mode and wake events, asynchronous pins.
  input  wire        progMode,
  input  wire        stopWake,
  // Programmer side address and store lookup.
  input  wire [14:0] progAddr,
  output wire [15:0] storeAddr,
  output wire        storeSel,
  output wire        optSel,
  output wire [2:0]  optIndex,
  // Option byte read port during loading.
  output reg  [2:0]  loadIndex_q,
  input  wire [7:0]  loadData,
  // Decoded options.
  output reg         porEnable_q,
  output reg         crystalSel_q,
  output reg  [4:0]  vacantBits_q,
  output reg  [15:0] pullupEnable_q,
  // Reset pin as open drain, oe low while driving.
  output reg         resetPinOut_q,
  output reg         resetPinOe_n_q,
  // Processor release.
  output reg         cpuRun_q
);

  // ************************************************
  // Input synchronisers
  // ************************************************
  reg [1:0] progSync_q;
  reg [1:0] wakeSync_q;
  reg       wakeLast_q;

  // The mode and wake pins are sampled twice before any logic looks at them.
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      progSync_q <= 2'h0;
      wakeSync_q <= 2'h0;
      wakeLast_q <= 1'b0;
    end
    else
    begin
      progSync_q <= {progSync_q[0], progMode};
      wakeSync_q <= {wakeSync_q[0], stopWake};
      wakeLast_q <= wakeSync_q[1];
    end
  end

  wire wakeRise = wakeSync_q[1] & ~wakeLast_q;

  // ************************************************
  // Programming-mode address map
  // ************************************************
  // The programmer holds the address steady for the whole access, as with any
  // plain EPROM, so the decode is combinational and the address is not resampled.
  // Programmer window is checked as a range; no signature address is decoded.
  function inRange;
    input [14:0] a;
    input [14:0] lo;
    input [14:0] hi;
    begin
      inRange = (a >= lo) && (a <= hi);
    end
  endfunction

  assign storeSel  = progSync_q[1] &
                     inRange(progAddr, `OOD_PROG_BASE, `OOD_PROG_TOP);
  assign storeAddr = `OOD_CPU_BASE | {2'h0, progAddr[13:0]};
  assign optSel    = progSync_q[1] &
                     inRange(progAddr, `OOD_OPT_FIRST, `OOD_OPT_LAST);
  assign optIndex  = progAddr[2:0];

  // ************************************************
  // Load sequencer
  // ************************************************
  localparam ST_LOAD = 3'h1;
  localparam ST_WAIT = 3'h2;
  localparam ST_RUN  = 3'h4;

  reg [2:0]  state_q;
  reg [17:0] waitCnt_q;
  reg        porDone_q;

  // Options are read one byte per cycle while the processor is held; the wait
  // length comes from the freshly latched byte, so it is settled before use.
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q        <= ST_LOAD;
      loadIndex_q    <= 3'h0;
      waitCnt_q      <= 18'h0;
      porDone_q      <= 1'b0;
      cpuRun_q       <= 1'b0;
      porEnable_q    <= 1'b1;
      crystalSel_q   <= 1'b1;
      vacantBits_q   <= 5'h1F;
      pullupEnable_q <= 16'h0000;
    end
    else
    begin
      case (state_q)
        ST_LOAD:
        begin
          cpuRun_q <= 1'b0;
          if (loadIndex_q == 3'h0)
          begin
            porEnable_q  <= loadData[`OOD_BIT_POR];
            crystalSel_q <= loadData[`OOD_BIT_XTAL];
            vacantBits_q <= loadData[7:3];
          end
          else if (loadIndex_q == 3'h1)
            pullupEnable_q[7:0] <= ~loadData;
          else if (loadIndex_q == 3'h2)
            pullupEnable_q[15:8] <= ~loadData;
          if (loadIndex_q == 3'h6)
          begin
            loadIndex_q <= 3'h0;
            // Wait only if power-on reset is enabled and not already served.
            if (porEnable_q && !porDone_q)
            begin
              waitCnt_q <= crystalSel_q ? `OOD_WAIT_XTAL : `OOD_WAIT_CERAMIC;
              state_q   <= ST_WAIT;
            end
            else
              state_q <= ST_RUN;
            porDone_q <= 1'b1;
          end
          else
            loadIndex_q <= loadIndex_q + 3'h1;
        end
        ST_WAIT:
        begin
          cpuRun_q <= 1'b0;
          if (waitCnt_q == 18'h0)
            state_q <= ST_RUN;
          else
            waitCnt_q <= waitCnt_q - 18'h1;
        end
        ST_RUN:
        begin
          cpuRun_q <= ~progSync_q[1];
          // Stop wake-up always waits, with either the crystal or the ceramic option.
          if (wakeRise)
          begin
            waitCnt_q <= crystalSel_q ? `OOD_WAIT_XTAL : `OOD_WAIT_CERAMIC;
            cpuRun_q  <= 1'b0;
            state_q   <= ST_WAIT;
          end
        end
        default:
        begin
          state_q  <= ST_LOAD;
          cpuRun_q <= 1'b0;
        end
      endcase
    end
  end

  // ************************************************
  // Reset pin output
  // ************************************************
  reg  rstOutOpt_q;
  wire rstOptNow;
  wire rstHeld;

  // The option bit is kept once the first byte has been read.
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rstOutOpt_q <= 1'b0;
    else if (state_q == ST_LOAD && loadIndex_q == 3'h0)
      rstOutOpt_q <= loadData[`OOD_BIT_RSTOUT];
  end

  // On the first load cycle the option comes straight from the store, so the
  // pin follows one cycle after reset release. Later load cycles present the
  // pull-up bytes, which must never steer the pin.
  assign rstOptNow = (state_q == ST_LOAD && loadIndex_q == 3'h0) ?
                     loadData[`OOD_BIT_RSTOUT] : rstOutOpt_q;

  // Internal reset counts as held until the sequencer reaches the run state.
  // Keying on the state keeps the pin release and the processor release on
  // the same edge, so they are never both active.
  assign rstHeld = (state_q != ST_RUN);

  // Pin is only driven low while internal reset holds and the option allows it.
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      resetPinOut_q  <= 1'b0;
      resetPinOe_n_q <= 1'b1;
    end
    else
    begin
      resetPinOut_q  <= 1'b0;
      resetPinOe_n_q <= ~(rstHeld & rstOptNow);
    end
  end

endmodule
`default_nettype wire

//--- common/ood_regs.vh
// Address map, option bit positions, erased byte value and timing counts of the option decoder.
`ifndef OOD_REGS_VH
`define OOD_REGS_VH

// Programmer-side addresses, 15 bits wide.
`define OOD_PROG_BASE      15'h4000
`define OOD_PROG_TOP       15'h7FFF
`define OOD_OPT_FIRST      15'h3FF0
`define OOD_OPT_LAST       15'h3FF6
`define OOD_OPT_COUNT      7

// Single-chip program window base, 16 bits wide.
`define OOD_CPU_BASE       16'hC000

// Bits of the first option byte.
`define OOD_BIT_POR        0
`define OOD_BIT_XTAL       1
`define OOD_BIT_RSTOUT     2

// Erased state of one option byte.
`define OOD_OPT_ERASED     8'hFF

// Stabilization waits in cycles of the 10 MHz clock (powers of two of the clock).
`define OOD_WAIT_XTAL      18'h3FFFF
`define OOD_WAIT_CERAMIC   18'h03FFF

`endif

//--- sim/ood_option_decode_props.sv
// Port checker for the option decoder.
`timescale 1ns/100ps
`default_nettype none
module ood_props (
  // Clock, reset and address map.
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [14:0] progAddr,
  input wire logic [15:0] storeAddr,
  input wire logic        storeSel,
  input wire logic        optSel,
  input wire logic [2:0]  optIndex,
  // Decoded options and release.
  input wire logic        porEnable_q,
  input wire logic        crystalSel_q,
  input wire logic [15:0] pullupEnable_q,
  input wire logic        resetPinOut_q,
  input wire logic        resetPinOe_n_q,
  input wire logic        cpuRun_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_MAP: assert property (storeSel |-> progAddr[14]
    && storeAddr == {2'b11, progAddr[13:0]}) else $error("bad map");
  AST_OPT: assert property (optSel |-> progAddr >= 15'h3FF0
    && progAddr <= 15'h3FF6 && optIndex == progAddr[2:0]) else $error("bad opt");
  AST_EXCL: assert property (!(optSel && storeSel)) else $error("both sel");
  AST_HOLD: assert property (cpuRun_q |=> $stable({porEnable_q,
    crystalSel_q, pullupEnable_q})) else $error("options moved");
  AST_PINLOW: assert property (!resetPinOe_n_q |-> !resetPinOut_q) else $error("pin");
  AST_PINREL: assert property (cpuRun_q |-> resetPinOe_n_q) else $error("pin held");
  AST_LOAD: assert property ($rose(cpuRun_q) |-> !$past(cpuRun_q, 8)) else $error("early");
  AST_WAIT: assert property ($fell(cpuRun_q) |=> !cpuRun_q [*8]) else $error("short");
endmodule
bind ood_option_decode ood_props u_ood_props (.clk, .reset_n, .progAddr, .storeAddr,
  .storeSel, .optSel, .optIndex, .porEnable_q, .crystalSel_q, .pullupEnable_q,
  .resetPinOut_q, .resetPinOe_n_q, .cpuRun_q);
`default_nettype wire

//--- sim/ood_opt_store.sv
// Option byte store model feeding the decoder's load reads.
`timescale 1ns/100ps
`default_nettype none
module ood_opt_store (
  // Load read port.
  input  wire logic [2:0] loadIndex,
  input  wire logic [7:0] firstByte,
  output var  logic [7:0] loadData
);
  // Same-cycle read; bytes past the third read erased.
  always_comb
    case (loadIndex)
      3'h0: loadData = firstByte;
      3'h1: loadData = 8'h5A;
      3'h2: loadData = 8'h0F;
      default: loadData = 8'hFF;
    endcase
endmodule
`default_nettype wire

//--- sim/ood_option_decode_tb.sv
// Self-checking bench for the option decoder.
`timescale 1ns/100ps
`default_nettype none
module ood_option_decode_tb;
  logic clk = 0, reset_n = 0, progMode = 0, stopWake = 0;
  logic [14:0] progAddr = 15'h0000;
  logic [7:0] opt0 = 8'hAD;
  wire logic [7:0] loadData;
  wire logic [2:0] idx, optIndex;
  wire logic [15:0] storeAddr, pull;
  wire logic [4:0] vac;
  wire logic storeSel, optSel, por, xtal, pinOut, pinOe_n, cpuRun_q;
  int errors = 0, testsRun = 0, n;
  ood_option_decode u_ood_option_decode (.clk, .reset_n, .progMode, .stopWake, .progAddr,
    .storeAddr, .storeSel, .optSel, .optIndex, .loadIndex_q(idx), .loadData,
    .porEnable_q(por), .crystalSel_q(xtal), .vacantBits_q(vac), .pullupEnable_q(pull),
    .resetPinOut_q(pinOut), .resetPinOe_n_q(pinOe_n), .cpuRun_q);
  ood_opt_store u_ood_opt_store (.loadIndex(idx), .firstByte(opt0), .loadData);
  // Free-running 10 MHz clock.
  initial
  begin
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, exp, input string what);
    testsRun++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stopTest();
    if (errors == 0 && testsRun > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Reset held for 12 cycles with the given first option byte, driven on an edge.
  task automatic rst(input logic [7:0] b0);
    @(posedge clk);
    opt0 <= b0;
    reset_n <= 1'b0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
  endtask
  // Bounded wait for processor release, counting cycles.
  task automatic waitRun();
    n = 0;
    while (cpuRun_q !== 1'b1 && n < 40000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (cpuRun_q !== 1'b1)
    begin
      errors++;
      stopTest();
    end
  endtask
  task automatic tPowerOn();
    rst(8'hAD);
    repeat (20) @(posedge clk);
    #1 chk(pinOe_n, 0, "pin oe");
    chk(pinOut, 0, "pin level");
    waitRun();
    chk(n >= 16364 && n <= 16390, 1, "por wait");
    chk({por, xtal, vac}, 7'h55, "byte0");
    chk(pull, 16'hF0A5, "pullups");
    chk(pinOe_n, 1, "pin rel");
  endtask
  task automatic tWake();
    @(posedge clk) stopWake <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk(cpuRun_q, 0, "stop");
    waitRun();
    chk(n >= 16370 && n <= 16390, 1, "wake wait");
    @(posedge clk) stopWake <= 1'b0;
  endtask
  // Crystal select, all vacant bits set and no reset pin output.
  task automatic tNoPor();
    rst(8'hFA);
    @(posedge clk);
    waitRun();
    chk(n <= 12, 1, "no wait");
    chk({por, xtal, vac, pinOe_n}, 8'h7F, "byte0 fa");
  endtask
  // Low addresses stand where a signature would sit and must stay unselected.
  task automatic tProg();
    logic [14:0] a[8] = '{15'h4000, 15'h7FFF, 15'h3FF0, 15'h3FF6,
                          15'h3FF7, 15'h3FEF, 15'h0000, 15'h0001};
    logic inOpt;
    @(posedge clk) progMode <= 1'b1;
    rst(8'h00);
    repeat (2) @(posedge clk);
    foreach (a[i])
    begin
      inOpt = (a[i] >= 15'h3FF0) && (a[i] <= 15'h3FF6);
      @(posedge clk) progAddr <= a[i];
      @(posedge clk) #1 chk({storeSel, optSel}, {a[i][14], inOpt}, "sel");
      if (a[i][14])
        chk(storeAddr, 16'hC000 + {2'h0, a[i][13:0]}, "addr");
      if (inOpt)
        chk(optIndex, a[i] - 15'h3FF0, "index");
    end
    repeat (40) @(posedge clk);
    #1 chk(cpuRun_q, 0, "prog hold");
  endtask
  // Main sequence.
  initial
  begin
    tPowerOn();
    tWake();
    tNoPor();
    tProg();
    stopTest();
  end
endmodule
`default_nettype wire
